// *** adc_readout_regs.svh ***
// Timing and format constants for the converter control and serial readout block.
// Assumes a 200 MHz core clock; included by the package only, whose include gives the design modules these macros.
`ifndef ADC_READOUT_REGS_SVH
`define ADC_READOUT_REGS_SVH

`define RESULT_BITS        18
`define CLK_PERIOD_PS      5000
`define CONV_TIME_NS       1000
`define CONV_CYCLES        ((`CONV_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define STEP_CYCLES        (`CONV_CYCLES / `RESULT_BITS)
`define BIT_CNT_W          5
`define STEP_CNT_W         8
`define SIGN_FLIP          18'h2_0000
`define RESULT_RESET       18'h0_0000

`endif

// *** adc_readout_pkg.sv ***
// Types shared by the converter control block.
// Assumes the constants header is on the include path.
`include "adc_readout_regs.svh"

package adc_readout_pkg;
    typedef enum logic [3:0] {
        ST_NAP     = 4'b0001,
        ST_ACQUIRE = 4'b0010,
        ST_CONVERT = 4'b0100,
        ST_LOAD    = 4'b1000
    } conv_state_t;
    typedef logic [`RESULT_BITS-1:0] code_t;
endpackage

// *** result_buffer.sv ***
// Two-entry result buffer with valid/ready on both sides.
// Assumes both sides run on the core clock.
`timescale 1ns/1ps

module result_buffer
#(
    parameter int WIDTH = 18,
    parameter int DEPTH = 2
)
(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Write side
    input  wire logic             wr_valid_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  wr_ready_out,
    // Read side
    output logic                  rd_valid_out,
    output logic [WIDTH-1:0]      rd_data_out,
    input  wire logic             rd_ready_in
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [PW:0]      cnt_q, cnt_d;
    logic [WIDTH-1:0] rd_q, rd_d;
    logic             rv_q, rv_d;
    logic             push, pop;

    // Read data always comes out of a register; the slot register refills on pop
    always_comb
    begin
        push  = wr_valid_in && (cnt_q != (PW+1)'(DEPTH));
        pop   = (cnt_q != '0) && (!rv_q || rd_ready_in);
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        rd_d  = rd_q;
        rv_d  = rv_q;
        if (rv_q && rd_ready_in)
        begin
            rv_d = 1'b0;
        end
        if (push)
        begin
            mem_d[wp_q] = wr_data_in;
            wp_d        = (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + PW'(1);
        end
        if (pop)
        begin
            rd_d = mem_q[rp_q];
            rv_d = 1'b1;
            rp_d = (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + PW'(1);
        end
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    // State registers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            rd_q  <= '0;
            rv_q  <= 1'b0;
        end
        else
        begin
            mem_q <= mem_d;
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            rd_q  <= rd_d;
            rv_q  <= rv_d;
        end
    end

    assign wr_ready_out = (cnt_q != (PW+1)'(DEPTH));
    assign rd_valid_out = rv_q;
    assign rd_data_out  = rd_q;
endmodule // result_buffer

// *** sar_adc_conversion_serial_readout.sv ***
// Conversion control and serial readout for an 18-bit successive-approximation
// converter. Assumes pins arrive asynchronous to clk_in and the comparator
// decision is a pin input as well; the serial clock is slow against clk_in.
// Limitation: every pin passes two flip-flops, so the serial clock must stay
// well below a quarter of the core clock or shift edges are missed.
// Trade-off: the comparator is synchronised too, which costs two core cycles of
// each step; the step length parameter must cover them.
//
// Overview of operation
// - A convert_start rising edge wakes the converter and begins a conversion.
// - Chain select low: shared pin enables or disables the serial output.
// - Chain select high: shared pin is the daisy-chain serial input.
// - Busy rises when conversion starts and falls when it completes.
// - Each serial clock rising edge while the output is enabled shifts out the next bit, MSB first.
// - The result is delivered in two's complement form.
// - Conversion resolves 18 binary-weighted steps, half reference down to 1/262144.
// - The finished code reaches the shifter through a two-entry buffer, three core cycles after busy falls.
// - Conversion is timed internally; the host only supplies the serial clock.
// - The converter naps by itself between conversions.
// - Acquisition and conversion phases alternate, back to acquisition after each.
`timescale 1ns/1ps

module sar_adc_conversion_serial_readout
    import adc_readout_pkg::*;
#(
    parameter int STEP_CYCLES = `STEP_CYCLES
)
(
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    // Host pins
    input  wire logic                    convert_start_in,
    input  wire logic                    chain_select_in,
    input  wire logic                    read_enable_or_chain_in_in,
    input  wire logic                    serial_clock_in,
    output logic                         busy_out,
    output logic                         serial_data_out,
    output logic                         serial_data_oe_out,
    // Analog core side
    input  wire logic                    comparator_in,
    output logic [`RESULT_BITS-1:0]      capacitor_dac_out,
    output logic                         sample_track_out,
    output logic                         nap_out
);
    // Two-stage synchronisers for every pin; stage one is read only by stage two
    logic [4:0] sync1_q, sync2_q, prev_q;
    logic       cnv_s, chain_s, rdl_s, sck_s, cmp_s;
    logic       cnv_rise, sck_rise;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end
        else
        begin
            sync1_q <= {convert_start_in, chain_select_in, read_enable_or_chain_in_in,
                        serial_clock_in, comparator_in};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign cnv_s    = sync2_q[4];
    assign chain_s  = sync2_q[3];
    assign rdl_s    = sync2_q[2];
    assign sck_s    = sync2_q[1];
    assign cmp_s    = sync2_q[0];
    assign cnv_rise = cnv_s && !prev_q[4];
    assign sck_rise = sck_s && !prev_q[1];

    // Conversion sequencer state
    conv_state_t            state_q, state_d;
    code_t                  trial_q, trial_d;     // Capacitor DAC code under test
    code_t                  weight_q, weight_d;   // Current binary weight
    logic [`STEP_CNT_W-1:0] step_q, step_d;
    logic                   busy_q, busy_d;
    logic                   load_q, load_d;
    code_t                  load_data_q, load_data_d;
    logic                   buf_ready;

    // Sequencer: nap, acquire, successive approximation, load result
    always_comb
    begin
        state_d     = state_q;
        trial_d     = trial_q;
        weight_d    = weight_q;
        step_d      = step_q;
        busy_d      = busy_q;
        load_d      = load_q && !buf_ready;
        load_data_d = load_data_q;
        case (state_q)
            ST_NAP, ST_ACQUIRE:
            begin
                // Input tracks in both; nap only idles the comparator and oscillator
                if (cnv_rise)
                begin
                    state_d  = ST_CONVERT;
                    busy_d   = 1'b1;
                    weight_d = `SIGN_FLIP;  // Half reference first
                    trial_d  = `SIGN_FLIP;
                    step_d   = '0;
                end
                else if (state_q == ST_ACQUIRE)
                begin
                    state_d = ST_NAP;
                end
            end
            ST_CONVERT:
            begin
                // Step timing from the internal cycle count, no host clock
                if (step_q == `STEP_CNT_W'(STEP_CYCLES - 1))
                begin
                    step_d = '0;
                    // Comparator high means sample is below trial: drop this bit
                    if (cmp_s)
                    begin
                        trial_d = trial_q & ~weight_q;
                    end
                    weight_d = weight_q >> 1;
                    if (weight_q[0])  // Last of 18 steps, weight 1/262144
                    begin
                        state_d = ST_LOAD;
                    end
                    else
                    begin
                        trial_d = (cmp_s ? (trial_q & ~weight_q) : trial_q) | (weight_q >> 1);
                    end
                end
                else
                begin
                    step_d = step_q + `STEP_CNT_W'(1);
                end
            end
            ST_LOAD:
            begin
                // Offset binary to two's complement by flipping the sign bit
                load_data_d = trial_q ^ `SIGN_FLIP;
                load_d      = 1'b1;
                busy_d      = 1'b0;
                state_d     = ST_ACQUIRE;
            end
            default:
            begin
                state_d = ST_NAP;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q     <= ST_NAP;
            trial_q     <= `RESULT_RESET;
            weight_q    <= `RESULT_RESET;
            step_q      <= '0;
            busy_q      <= 1'b0;
            load_q      <= 1'b0;
            load_data_q <= `RESULT_RESET;
        end
        else
        begin
            state_q     <= state_d;
            trial_q     <= trial_d;
            weight_q    <= weight_d;
            step_q      <= step_d;
            busy_q      <= busy_d;
            load_q      <= load_d;
            load_data_q <= load_data_d;
        end
    end

    // Phase flags registered from the next state, so they switch together with
    // state_q and the pins never show a glitch from decoding the one-hot code
    logic track_q, track_d;
    logic nap_q, nap_d;

    always_comb
    begin
        // Input tracks in every phase but conversion
        track_d = (state_d != ST_CONVERT);
        // Nap flag follows the nap state only
        nap_d   = (state_d == ST_NAP);
    end

    // Phase flag registers; reset leaves the converter napping and tracking
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            track_q <= 1'b1;
            nap_q   <= 1'b1;
        end
        else
        begin
            track_q <= track_d;
            nap_q   <= nap_d;
        end
    end

    // Buffer between conversion and readout; its word goes to the shifter as soon as no conversion runs
    logic  rd_valid, rd_take;
    code_t rd_data;

    result_buffer #(.WIDTH(`RESULT_BITS), .DEPTH(2)) u_buf
    (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .wr_valid_in  (load_q),
        .wr_data_in   (load_data_q),
        .wr_ready_out (buf_ready),
        .rd_valid_out (rd_valid),
        .rd_data_out  (rd_data),
        .rd_ready_in  (rd_take)
    );

    // Shift register state
    code_t shift_q, shift_d;
    logic  sdo_q, sdo_d;
    logic  oe_q, oe_d;

    // Take a fresh result only while no conversion runs, so a frame is not torn
    assign rd_take = rd_valid && !busy_q && (state_q != ST_CONVERT);

    // Serial shifter: load on new result, shift on serial clock edges
    always_comb
    begin
        shift_d = shift_q;
        sdo_d   = sdo_q;
        // Normal mode: low on the shared pin enables the output
        oe_d    = chain_s ? 1'b1 : !rdl_s;
        if (rd_take)
        begin
            shift_d = rd_data;
            sdo_d   = rd_data[`RESULT_BITS-1];
        end
        else if (sck_rise && oe_q)
        begin
            // Chain mode pulls in upstream data behind our own bits
            shift_d = {shift_q[`RESULT_BITS-2:0], chain_s ? rdl_s : 1'b0};
            sdo_d   = shift_q[`RESULT_BITS-2];  // MSB first
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            shift_q <= `RESULT_RESET;
            sdo_q   <= 1'b0;
            oe_q    <= 1'b0;
        end
        else
        begin
            shift_q <= shift_d;
            sdo_q   <= sdo_d;
            oe_q    <= oe_d;
        end
    end

    // Outputs straight from flip-flops
    assign busy_out           = busy_q;
    assign serial_data_out    = sdo_q;
    assign serial_data_oe_out = oe_q;
    assign capacitor_dac_out  = trial_q;
    assign sample_track_out   = track_q;
    assign nap_out            = nap_q;
endmodule // sar_adc_conversion_serial_readout

// *** adc_readout_sva.sv ***
// Assertion checker for the converter control block, bound to its top.
// Assumes all pins are sampled on clk_in and rst_in clears the state.
`timescale 1ns/1ps

module adc_readout_sva
    import adc_readout_pkg::*;
#(
    parameter int STEP_CYCLES = 11
)
(
    // Clock and reset
    input wire logic                     clk_in,
    input wire logic                     rst_in,
    // Host pins
    input wire logic                     convert_start_in,
    input wire logic                     chain_select_in,
    input wire logic                     read_enable_or_chain_in_in,
    input wire logic                     serial_clock_in,
    input wire logic                     busy_out,
    input wire logic                     serial_data_out,
    input wire logic                     serial_data_oe_out,
    // Analog core side
    input wire logic                     comparator_in,
    input wire logic [`RESULT_BITS-1:0]  capacitor_dac_out,
    input wire logic                     sample_track_out,
    input wire logic                     nap_out
);
    localparam int BUSY_MIN = 18 * STEP_CYCLES - 1;
    localparam int BUSY_MAX = 18 * STEP_CYCLES + 3;
    logic [7:0] quiet_q, quiet_d;
    logic [9:0] run_q, run_d;
    logic       sck_q, busy_q;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Time since a shift or a load, and length of the busy run
    always_comb
    begin
        quiet_d = (quiet_q == 8'hff) ? quiet_q : quiet_q + 8'h01;
        if ((serial_clock_in && !sck_q) || (busy_q && !busy_out))
            quiet_d = 8'h00;
        run_d = busy_out ? run_q + 10'h001 : 10'h000;
    end
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            {quiet_q, run_q, sck_q, busy_q} <= {8'hff, 10'h000, 2'b00};
        else
            {quiet_q, run_q, sck_q, busy_q} <= {quiet_d, run_d, serial_clock_in, busy_out};
    end

    sequence conv_begin;
        $rose(busy_out);
    endsequence
    sequence conv_end;
        $fell(busy_out);
    endsequence

    start_on_edge_a: assert property ($rose(convert_start_in) && nap_out |-> ##[1:6] busy_out)
        else $error("convert edge did not start a conversion");
    busy_ends_a: assert property (conv_begin |-> ##[BUSY_MIN:BUSY_MAX] !busy_out)
        else $error("busy did not fall in time");
    busy_length_a: assert property (conv_end |-> run_q >= 10'(BUSY_MIN))
        else $error("conversion ended too early");
    first_trial_a: assert property (conv_begin |-> capacitor_dac_out == 18'h2_0000)
        else $error("first trial code is not half scale");
    phase_change_a: assert property (conv_begin |-> !sample_track_out && !nap_out)
        else $error("still tracking or napping while converting");
    nap_after_a: assert property (conv_end |-> ##[1:8] nap_out && sample_track_out)
        else $error("no nap after conversion");
    normal_enable_a: assert property ((!chain_select_in && !read_enable_or_chain_in_in)[*6]
        |-> serial_data_oe_out)
        else $error("output not enabled");
    normal_disable_a: assert property ((!chain_select_in && read_enable_or_chain_in_in)[*6]
        |-> !serial_data_oe_out)
        else $error("output not disabled");
    chain_drive_a: assert property (chain_select_in[*6] |-> serial_data_oe_out)
        else $error("output not driven in chain mode");
    shift_cause_a: assert property ($changed(serial_data_out) |-> quiet_q <= 8'h06)
        else $error("serial data changed without a shift or load");
endmodule // adc_readout_sva

bind sar_adc_conversion_serial_readout adc_readout_sva #(.STEP_CYCLES(STEP_CYCLES)) u_sva (
    .clk_in(clk_in), .rst_in(rst_in), .convert_start_in(convert_start_in),
    .chain_select_in(chain_select_in), .read_enable_or_chain_in_in(read_enable_or_chain_in_in),
    .serial_clock_in(serial_clock_in), .busy_out(busy_out), .serial_data_out(serial_data_out),
    .serial_data_oe_out(serial_data_oe_out), .comparator_in(comparator_in),
    .capacitor_dac_out(capacitor_dac_out), .sample_track_out(sample_track_out),
    .nap_out(nap_out));

// *** host_model.sv ***
// Host controller model: convert pulses, serial clock and the shared pin.
// Assumes a 5 ns core clock; every pin changes 1 ns after a rising edge.
`timescale 1ns/1ps

module host_model
(
    // Clock and device pins
    input  wire logic clk_in,
    input  wire logic busy_in,
    input  wire logic sdo_in,
    output logic      convert_start_out,
    output logic      serial_clock_out,
    output logic      shared_pin_out
);
    // Serial clock stands low outside frames
    initial
    begin
        {convert_start_out, serial_clock_out, shared_pin_out} = 3'b000;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Pulse held 40 ns so the synchroniser cannot miss it
    task automatic start();
        convert_start_out = 1'b1;
        tick(8);
        convert_start_out = 1'b0;
        tick(8);
    endtask
    task automatic pin(input logic v);
        shared_pin_out = v;
        tick(8);
    endtask
    // Readout only after busy falls, bounded so a hang is seen
    task automatic wait_idle(output logic ok);
        int n;
        n = 0;
        while (busy_in !== 1'b0 && n < 2000)
        begin
            tick(1);
            n++;
        end
        ok = (n < 2000);
        tick(8);
    endtask
    // 80 ns period, far above the chain minimum; sdo taken before each rise
    task automatic frame(input int n, input logic [35:0] din, input logic chain,
                         output logic [35:0] dout);
        dout = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            if (chain)
                shared_pin_out = din[i];
            tick(8);
            dout[i] = sdo_in;
            serial_clock_out = 1'b1;
            tick(8);
            serial_clock_out = 1'b0;
        end
        if (chain)
            shared_pin_out = ~shared_pin_out; // Released line shows no stale bit
    endtask
endmodule // host_model

// *** sar_adc_conversion_serial_readout_test.sv ***
// Self-checking bench for the converter control and serial readout block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module sar_adc_conversion_serial_readout_test
    import adc_readout_pkg::*;
;
    localparam int STEPS = 11;
    logic       clk_in = 1'b0;
    logic       rst_in, chain_select_in;
    code_t      target_q, dac;
    logic       busy, sdo, oe, track, nap, conv, sck, shared;
    int         mismatches = 0, comparisons = 0, cycles = 0;

    always #2.5 clk_in = ~clk_in;
    // Analog core: trial above the held sample clears the bit
    sar_adc_conversion_serial_readout #(.STEP_CYCLES(STEPS)) u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .convert_start_in(conv),
        .chain_select_in(chain_select_in), .read_enable_or_chain_in_in(shared),
        .serial_clock_in(sck), .busy_out(busy), .serial_data_out(sdo),
        .serial_data_oe_out(oe), .comparator_in(dac > target_q),
        .capacitor_dac_out(dac), .sample_track_out(track), .nap_out(nap));
    host_model u_host (.clk_in(clk_in), .busy_in(busy), .sdo_in(sdo),
        .convert_start_out(conv), .serial_clock_out(sck), .shared_pin_out(shared));

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic convert(input code_t code);
        logic ok;
        target_q = code;
        u_host.start();
        u_host.wait_idle(ok);
        check("conversion done", ok, 1'b1);
    endtask
    // Cycle ceiling: the whole run needs well under 10000 cycles
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            results();
        end
    end

    task automatic test_codes();
        code_t codes [5] = '{18'h0_0000, 18'h3_ffff, 18'h2_0000, 18'h1_ffff, 18'h1_2345};
        logic [35:0] w;
        foreach (codes[i])
        begin
            convert(codes[i]);
            check("normal oe", oe, 1'b1);
            u_host.frame(18, 36'h0_0000_0000, 1'b0, w);
            check("normal word", w[17:0], codes[i] ^ `SIGN_FLIP);
        end
        $display("test_codes done");
    endtask
    // Clocks while disabled must not consume result bits
    task automatic test_disable();
        logic [35:0] w;
        convert(18'h0_5a5a);
        u_host.pin(1'b1);
        check("disabled oe", oe, 1'b0);
        u_host.frame(3, 36'h0_0000_0000, 1'b0, w);
        u_host.pin(1'b0);
        u_host.frame(18, 36'h0_0000_0000, 1'b0, w);
        check("word after disable", w[17:0], 18'h0_5a5a ^ `SIGN_FLIP);
        $display("test_disable done");
    endtask
    // A second edge in mid-conversion is ignored and queues nothing
    task automatic test_ignore();
        logic [35:0] w;
        logic ok;
        target_q = 18'h2_abcd;
        u_host.start();
        check("busy converting", busy, 1'b1);
        check("not tracking", track, 1'b0);
        u_host.start();
        u_host.wait_idle(ok);
        check("conversion done", ok, 1'b1);
        u_host.tick(20);
        check("no second conversion", busy, 1'b0);
        check("napping", nap, 1'b1);
        check("tracking", track, 1'b1);
        u_host.frame(18, 36'h0_0000_0000, 1'b0, w);
        check("word after ignore", w[17:0], 18'h2_abcd ^ `SIGN_FLIP);
        $display("test_ignore done");
    endtask
    task automatic test_chain();
        logic [35:0] w;
        chain_select_in = 1'b1;
        convert(18'h0_0f0f);
        check("chain oe", oe, 1'b1);
        u_host.frame(36, {18'h2_c3a5, 18'h0_0000}, 1'b1, w);
        check("chain own", w[35:18], 18'h0_0f0f ^ `SIGN_FLIP);
        check("chain upstream", w[17:0], 18'h2_c3a5);
        chain_select_in = 1'b0;
        u_host.pin(1'b0);
        $display("test_chain done");
    endtask

    // Reset for 4 cycles, outputs checked while it is held
    initial
    begin
        {rst_in, chain_select_in, target_q} = {2'b10, 18'h0_0000};
        u_host.tick(3);
        check("reset outputs", {busy, oe, nap, track, dac}, {4'b0011, 18'h0_0000});
        u_host.tick(1);
        rst_in = 1'b0;
        u_host.tick(4);
        test_codes();
        test_disable();
        test_ignore();
        test_chain();
        results();
    end
endmodule // sar_adc_conversion_serial_readout_test
